// ---- lfc_top.sv ----
// lock bits, configuration fuse row and completion polling behind an apb slave
//
// Summary of operation
// - busy read of last written byte returns it with msb inverted
// - during erase a poll of code or data returns 7fh
// - page poll value is the last byte loaded, not highest address
// - two lock bits, ffh or 00h; both ffh means no protection
// - only chip erase returns lock bits to ffh
// - mode 2 refuses external programming of code, data, signature and fuses; lock bits stay writable
// - mode 3 also refuses code and data reads and kills debug
// - software initiated memory writes ignore the lock bits
// - eleven fuses, each at its own fuse row address
// - writing 00h clears a fuse, ffh leaves it unchanged
// - fuses return to ffh only by auto-erase fuse write
// - every fuse reads ffh by default
// - fuse pair 1,0 selects crystal, slow crystal, external or rc clock
// - start-up fuse pair sets wake-up timeout per clock kind
// - fuse 04h chooses reset input or general purpose pin
// - fuse 06h enables on-chip debug when 00h
// - programming fuse cleared allows programming entry only during power-on
// - fuse 08h enables external user signature programming when 00h
// - fuse 09h sets port start mode; fuse 0ah must stay ffh
// - clock and start-up fuses apply only at power-on reset
// - reset pin and programming fuses apply at session end
// - each address one fuse or lock bit; data only 00h or ffh
`timescale 1ns/10ps
`default_nettype none

module lfc_top
  import lfc_pkg::*;
(
  input  wire logic        mclk_i,              // system clock
  input  wire logic        reset_i,             // synchronous reset
  input  wire logic        psel_i,              // apb select
  input  wire logic        penable_i,           // apb enable
  input  wire logic        pwrite_i,            // apb direction
  input  wire logic [7:0]  paddr_i,             // apb byte address
  input  wire logic [31:0] pwdata_i,            // apb write data
  output logic      [31:0] prdata_o,            // apb read data
  output logic             pready_o,            // apb ready
  output logic             pslverr_o,           // apb error
  input  wire logic        por_i,               // power-on reset active
  input  wire logic        session_end_i,       // reset pin rose, session over
  output lfc_clk_t         clock_source_o,      // selected clock source
  output logic      [15:0] startup_us_o,        // wake-up timeout in us
  output logic             reset_pin_is_reset_o, // reset pin acts as reset
  output logic             bod_fuse_o,          // brownout fuse image
  output logic             on_chip_debug_en_o,  // debug link enabled
  output logic             isp_entry_allowed_o, // programming entry allowed
  output logic             usig_prog_en_o,      // user signature writable
  output logic             ports_tristate_o,    // ports start as inputs
  output logic       [1:0] lock_mode_o,         // protection mode 1 to 3
  output logic             busy_o               // programming cycle running
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] lock_mode(input logic [1:0] lk);
    if (!lk[0] && !lk[1])
      lock_mode = 2'h3;
    else if (!lk[0])
      lock_mode = 2'h2;
    else
      lock_mode = 2'h1;
  endfunction

  function automatic logic [15:0] startup_us(input lfc_clk_t src, input logic [1:0] sut);
    logic xt;
    xt = (src == CLK_CRYSTAL_OSCILLATOR_HS) || (src == CLK_CRYSTAL_OSCILLATOR_LS);
    case (sut)
      2'h0:    startup_us = xt ? SUT0_CRYSTAL_OSCILLATOR_US : SUT0_FAST_US;
      2'h1:    startup_us = xt ? SUT1_CRYSTAL_OSCILLATOR_US : SUT1_FAST_US;
      2'h2:    startup_us = xt ? SUT2_CRYSTAL_OSCILLATOR_US : SUT2_FAST_US;
      default: startup_us = xt ? SUT3_CRYSTAL_OSCILLATOR_US : SUT3_FAST_US;
    endcase
  endfunction

  function automatic logic [5:0] mem_idx(input lfc_space_t sp, input logic [3:0] a);
    mem_idx = {sp[1:0], a};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        refused;
  logic [7:0]  cnt;
  lfc_op_t     run_op;
  lfc_space_t  run_space;
  logic [7:0]  poll_val;
  logic [3:0]  poll_addr;
  logic [10:0] fuse;
  logic [1:0]  lock;
  lfc_cfg_t    cfg;
  lfc_cfg_t    next_cfg;
  logic [15:0] pmask;
  logic [7:0]  pbuf [0:15];
  logic [7:0]  mem  [0:47];

  logic        acc;
  logic        wr;
  logic        cmd_go;
  lfc_cmd_t    cmd;
  logic        busy;
  logic        done;
  logic [1:0]  mode;
  logic        data_ok;
  logic        cmd_bad;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [7:0]  rd_byte;

  assign acc    = psel_i & penable_i & pready_o;
  assign wr     = acc & pwrite_i;
  assign cmd_go = wr && (paddr_i == OFF_CMD);
  assign cmd    = lfc_cmd_t'(pwdata_i[7:0]);
  assign busy   = (cnt != 8'h00);
  assign done   = (cnt == 8'h01);
  assign mode   = lock_mode(lock);
  assign data_ok = (wdata == BYTE_CLR) || (wdata == BYTE_SET);

  ////////////////////////////////////////////////////////////////////////////
  // command acceptance

  always_comb
  begin
    cmd_bad = 1'b0;
    case (cmd.op)
      OP_NOP:
        cmd_bad = 1'b0;
      OP_LOAD, OP_WRPAGE:
      begin
        cmd_bad = (cmd.space > SP_USIG) || (!cmd.sw && (mode != 2'h1));
        if (cmd.space == SP_USIG && !cmd.sw && cfg.usig_off)
          cmd_bad = 1'b1;
      end
      OP_ERASE:
        cmd_bad = 1'b0;
      OP_WRFUSE, OP_WRFUSE_AE:
      begin
        // fuses locked in mode 2 and 3, eleven addresses
        cmd_bad = (mode != 2'h1) || (addr > {4'h0, FUSE_LAST}) || !data_ok;
        if (addr[3:0] == FUSE_OCDSEL && wdata == BYTE_CLR)
          cmd_bad = 1'b1;
      end
      OP_WRLOCK:
        cmd_bad = (addr > LOCK_LAST) || !data_ok;
      OP_READ:
      begin
        // mode 3 blocks code and data reads only
        cmd_bad = (cmd.space > SP_LOCK) || (mode == 2'h3 && cmd.space <= SP_DATA);
        if (cmd.space == SP_FUSE && addr > {4'h0, FUSE_LAST})
          cmd_bad = 1'b1;
        if (cmd.space == SP_LOCK && addr > LOCK_LAST)
          cmd_bad = 1'b1;
      end
      default:
        cmd_bad = 1'b1;
    endcase
    if (busy && cmd.op != OP_READ && cmd.op != OP_NOP)
      cmd_bad = 1'b1;
  end

  always_comb
  begin
    rd_byte = mem[mem_idx(cmd.space, addr[3:0])];
    case (cmd.space)
      SP_CODE, SP_DATA, SP_USIG:
      begin
        if (busy && run_op == OP_ERASE && cmd.space <= SP_DATA)
          rd_byte = ERASE_POLL;
        // inverted msb on last loaded byte
        else if (busy && run_op == OP_WRPAGE && cmd.space == run_space &&
                 addr[3:0] == poll_addr)
          rd_byte = poll_val ^ POLL_FLIP;
      end
      SP_FUSE:
        rd_byte = fuse[addr[3:0]] ? BYTE_SET : BYTE_CLR;
      SP_LOCK:
        rd_byte = lock[addr[0]] ? BYTE_SET : BYTE_CLR;
      default:
        rd_byte = BYTE_CLR;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (paddr_i)
      OFF_CMD:    rd_word = 32'h0000_0000;
      OFF_ADDR:   rd_word = {24'h00_0000, addr};
      OFF_WDATA:  rd_word = {24'h00_0000, wdata};
      OFF_RDATA:  rd_word = {24'h00_0000, rdata};
      OFF_STATUS: rd_word = {27'h000_0000, busy && run_op == OP_ERASE, mode, refused, busy};
      OFF_FUSES:  rd_word = {21'h00_0000, fuse};
      OFF_CFG:    rd_word = {21'h00_0000, cfg};
      default:    rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      prdata_o  <= rd_word;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~rd_ok;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      addr  <= 8'h00;
      wdata <= 8'h00;
    end
    else
    begin
      if (wr && paddr_i == OFF_ADDR)
        addr <= pwdata_i[7:0];
      if (wr && paddr_i == OFF_WDATA)
        wdata <= pwdata_i[7:0];
    end
  end

  // refused flag: a new refusal wins over the clear
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      refused <= 1'b0;
    else if (cmd_go && cmd_bad)
      refused <= 1'b1;
    else if (wr && paddr_i == OFF_STATUS && pwdata_i[ST_REFUSED])
      refused <= 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      rdata <= 8'h00;
    else if (cmd_go && !cmd_bad && cmd.op == OP_READ)
      rdata <= rd_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming cycle and page buffer

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      cnt       <= 8'h00;
      run_op    <= OP_NOP;
      run_space <= SP_CODE;
    end
    else if (cmd_go && !cmd_bad && (cmd.op == OP_WRPAGE || cmd.op == OP_ERASE))
    begin
      cnt       <= PROG_CYCLES;
      run_op    <= cmd.op;
      run_space <= cmd.space;
    end
    else if (busy)
      cnt <= cnt - 8'h01;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pmask     <= 16'h0000;
      poll_val  <= 8'h00;
      poll_addr <= 4'h0;
    end
    else if (cmd_go && !cmd_bad && cmd.op == OP_LOAD)
    begin
      pbuf[addr[3:0]]  <= wdata;
      pmask[addr[3:0]] <= 1'b1;
      poll_val  <= wdata;
      poll_addr <= addr[3:0];
    end
    else if (done && run_op == OP_WRPAGE)
      pmask <= 16'h0000;
  end

  always_ff @(posedge mclk_i)
  begin
    if (done && run_op == OP_WRPAGE)
    begin
      for (int i = 0; i < 16; i++)
        if (pmask[i])
          mem[mem_idx(run_space, 4'(i))] <= pbuf[i];
    end
    else if (done && run_op == OP_ERASE)
    begin
      // signature page only when its programming fuse is enabled
      for (int i = 0; i < 48; i++)
        if (i < 32 || !cfg.usig_off)
          mem[i] <= BYTE_SET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fuse row and lock bits

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      fuse <= FUSE_RESET;
    else if (cmd_go && !cmd_bad && cmd.op == OP_WRFUSE_AE)
    begin
      // row erased then this byte written
      fuse <= FUSE_RESET;
      if (wdata == BYTE_CLR)
        fuse[addr[3:0]] <= 1'b0;
    end
    else if (cmd_go && !cmd_bad && cmd.op == OP_WRFUSE && wdata == BYTE_CLR)
      fuse[addr[3:0]] <= 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      lock <= LOCK_RESET;
    else if (done && run_op == OP_ERASE)
      lock <= LOCK_RESET;
    else if (cmd_go && !cmd_bad && cmd.op == OP_WRLOCK && wdata == BYTE_CLR)
      lock[addr[0]] <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched configuration

  always_comb
  begin
    next_cfg = lfc_cfg_t'(fuse);
    // clock and start-up held until power-on
    if (!por_i)
    begin
      next_cfg.clk_src = cfg.clk_src;
      next_cfg.sut     = cfg.sut;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      cfg <= lfc_cfg_t'(FUSE_RESET);
    // latch at power-on or session end
    else if (por_i || session_end_i)
      cfg <= next_cfg;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      clock_source_o       <= CLK_IRC;
      startup_us_o         <= SUT3_FAST_US;
      reset_pin_is_reset_o <= 1'b1;
      bod_fuse_o           <= 1'b1;
      on_chip_debug_en_o   <= 1'b0;
      isp_entry_allowed_o  <= 1'b1;
      usig_prog_en_o       <= 1'b0;
      ports_tristate_o     <= 1'b1;
      lock_mode_o          <= 2'h1;
      busy_o               <= 1'b0;
    end
    else
    begin
      clock_source_o       <= cfg.clk_src;
      startup_us_o         <= startup_us(cfg.clk_src, cfg.sut);
      reset_pin_is_reset_o <= cfg.rst_is_reset;
      bod_fuse_o           <= cfg.bod_fuse;
      on_chip_debug_en_o   <= !cfg.debug_off && (mode != 2'h3);
      isp_entry_allowed_o  <= cfg.isp_on || por_i;
      usig_prog_en_o       <= !cfg.usig_off && (mode == 2'h1);
      ports_tristate_o     <= cfg.tristate;
      lock_mode_o          <= mode;
      busy_o               <= busy;
    end
  end

endmodule

`default_nettype wire

// ---- lfc_pkg.sv ----
// constants, enumerations and carriers for the lock, fuse and polling block
package lfc_pkg;

  // timing
  localparam int         CLK_PERIOD_NS = 5;
  localparam int         PROG_TIME_NS  = 1000;
  localparam logic [7:0] PROG_CYCLES   = 8'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register byte offsets
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_RDATA  = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_FUSES  = 8'h14;
  localparam logic [7:0] OFF_CFG    = 8'h18;

  // status bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_REFUSED = 1;

  // byte values
  localparam logic [7:0] BYTE_SET   = 8'hff;
  localparam logic [7:0] BYTE_CLR   = 8'h00;
  localparam logic [7:0] POLL_FLIP  = 8'h80;
  localparam logic [7:0] ERASE_POLL = 8'h7f;

  // fuse row and lock bits
  localparam int          FUSE_COUNT  = 11;
  localparam logic [3:0]  FUSE_LAST   = 4'ha;
  localparam logic [3:0]  FUSE_OCDSEL = 4'ha;
  localparam logic [10:0] FUSE_RESET  = 11'h7ff;
  localparam logic [1:0]  LOCK_RESET  = 2'h3;
  localparam logic [7:0]  LOCK_LAST   = 8'h01;

  // start-up timeouts in microseconds, crystal and fast clocks
  localparam logic [15:0] SUT0_CRYSTAL_OSCILLATOR_US = 16'h03e8;
  localparam logic [15:0] SUT0_FAST_US = 16'h0010;
  localparam logic [15:0] SUT1_CRYSTAL_OSCILLATOR_US = 16'h07d0;
  localparam logic [15:0] SUT1_FAST_US = 16'h0200;
  localparam logic [15:0] SUT2_CRYSTAL_OSCILLATOR_US = 16'h0fa0;
  localparam logic [15:0] SUT2_FAST_US = 16'h03e8;
  localparam logic [15:0] SUT3_CRYSTAL_OSCILLATOR_US = 16'h3e80;
  localparam logic [15:0] SUT3_FAST_US = 16'h0fa0;

  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_LOAD      = 4'h1,
    OP_WRPAGE    = 4'h2,
    OP_ERASE     = 4'h3,
    OP_WRFUSE    = 4'h4,
    OP_WRFUSE_AE = 4'h5,
    OP_WRLOCK    = 4'h6,
    OP_READ      = 4'h7
  } lfc_op_t;

  typedef enum logic [2:0] {
    SP_CODE = 3'h0,
    SP_DATA = 3'h1,
    SP_USIG = 3'h2,
    SP_FUSE = 3'h3,
    SP_LOCK = 3'h4
  } lfc_space_t;

  typedef enum logic [1:0] {
    CLK_CRYSTAL_OSCILLATOR_HS = 2'h0,
    CLK_CRYSTAL_OSCILLATOR_LS = 2'h1,
    CLK_EXT     = 2'h2,
    CLK_IRC     = 2'h3
  } lfc_clk_t;

  typedef struct packed {
    logic       sw;
    lfc_space_t space;
    lfc_op_t    op;
  } lfc_cmd_t;

  // fuse row image, bit 10 down to bit 0; a one means the fuse reads ffh
  typedef struct packed {
    logic       ocd_fast;
    logic       tristate;
    logic       usig_off;
    logic       isp_on;
    logic       debug_off;
    logic       bod_fuse;
    logic       rst_is_reset;
    logic [1:0] sut;
    lfc_clk_t   clk_src;
  } lfc_cfg_t;

endpackage

// ---- lfc_asserts.sv ----
// port assertions for the lock, fuse and polling block
`timescale 1ns/10ps
`default_nettype none

module lfc_asserts
  import lfc_pkg::*;
(
  input wire logic        mclk_i,               // clock
  input wire logic        reset_i,              // reset
  input wire logic        psel_i,               // select
  input wire logic        penable_i,            // enable
  input wire logic        pwrite_i,             // direction
  input wire logic [31:0] prdata_o,             // read data
  input wire logic        pready_o,             // ready
  input wire logic        pslverr_o,            // error
  input wire logic        por_i,                // power-on
  input wire logic        session_end_i,        // session over
  input wire lfc_clk_t    clock_source_o,       // clock pick
  input wire logic [15:0] startup_us_o,         // timeout
  input wire logic        reset_pin_is_reset_o, // pin use
  input wire logic        on_chip_debug_en_o,   // debug
  input wire logic        isp_entry_allowed_o,  // entry
  input wire logic        usig_prog_en_o,       // signature
  input wire logic [1:0]  lock_mode_o,          // mode
  input wire logic        busy_o                // busy
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  logic [7:0] busy_cnt;
  logic [2:0] se_h;
  logic [2:0] por_h;

  // recent latch events and length of the running cycle
  always_ff @(posedge mclk_i)
  begin
    se_h  <= reset_i ? 3'h0 : {se_h[1:0], session_end_i};
    por_h <= reset_i ? 3'h0 : {por_h[1:0], por_i};
    busy_cnt <= (reset_i || !busy_o) ? 8'h00 : busy_cnt + 8'h01;
  end

  ////////////////////////////////////////////////////////////
  chk_ready_late: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
    else $error("ready not in second access cycle");
  chk_ready_once: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  chk_err_zero: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("refused read returned data");
  chk_busy_len: assert property ($fell(busy_o) |-> busy_cnt == PROG_CYCLES)
    else $error("programming cycle length wrong");
  chk_lock_range: assert property (lock_mode_o != 2'h0)
    else $error("lock mode out of range");
  chk_debug_mode3: assert property (lock_mode_o == 2'h3 && $past(lock_mode_o) == 2'h3
    |-> !on_chip_debug_en_o) else $error("debug alive in mode 3");
  chk_usig_mode1: assert property (lock_mode_o != 2'h1 && $past(lock_mode_o) != 2'h1
    |-> !usig_prog_en_o) else $error("signature writable while locked");
  chk_clock_hold: assert property (!$stable(clock_source_o) |-> |por_h)
    else $error("clock source moved without power-on");
  chk_sut_hold: assert property (!$stable(startup_us_o) |-> |por_h)
    else $error("timeout moved without power-on");
  chk_pin_hold: assert property (!$stable(reset_pin_is_reset_o) |-> |se_h || |por_h)
    else $error("reset pin use moved mid-session");
  chk_isp_por: assert property (por_i |=> isp_entry_allowed_o)
    else $error("entry refused during power-on");

  cover property (lock_mode_o == 2'h3);
  cover property ($fell(busy_o));
  cover property (pready_o && pslverr_o);
endmodule

bind lfc_top lfc_asserts u_lfc_asserts (
  .mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .prdata_o, .pready_o,
  .pslverr_o, .por_i, .session_end_i, .clock_source_o, .startup_us_o,
  .reset_pin_is_reset_o, .on_chip_debug_en_o, .isp_entry_allowed_o,
  .usig_prog_en_o, .lock_mode_o, .busy_o
);
`default_nettype wire

// ---- lfc_prog.sv ----
// programmer model: apb master issuing programming requests
`timescale 1ns/10ps
`default_nettype none

module lfc_prog
  import lfc_pkg::*;
(
  input  wire logic        mclk_i,    // clock
  output logic             psel_o,    // select
  output logic             penable_o, // enable
  output logic             pwrite_o,  // direction
  output logic      [7:0]  paddr_o,   // address
  output logic      [31:0] pwdata_o,  // write data
  input  wire logic [31:0] prdata_i,  // read data
  input  wire logic        pready_i,  // ready
  input  wire logic        pslverr_i  // error
);
  logic [31:0] q;
  logic        e;

  initial
  begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0;
  end

  ////////////////////////////////////////////////////////////
  // one transfer; released address and data lines show the inverse of their last value
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_o   <= 1'b1;
    pwrite_o <= wr;
    paddr_o  <= a;
    pwdata_o <= d;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    do
      @(posedge mclk_i);
    while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask

  task automatic nv(input lfc_op_t op, input lfc_space_t sp, input logic sw,
                    input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, OFF_ADDR, {24'h0, a});
    xfer(1'b1, OFF_WDATA, {24'h0, d});
    xfer(1'b1, OFF_CMD, {24'h0, sw, sp, op});
  endtask

  // one fuse, data 00h or ffh
  task automatic fuse(input logic [7:0] a, input logic keep);
    nv(OP_WRFUSE, SP_FUSE, 1'b0, a, {8{keep}});
  endtask
endmodule
`default_nettype wire

// ---- lfc_bench.sv ----
// self-checking bench for the lock, fuse and polling block
`timescale 1ns/10ps
`default_nettype none

module lfc_bench
  import lfc_pkg::*;
;
  localparam logic [7:0]  fz [5]      = '{8'h04, 8'h06, 8'h07, 8'h08, 8'h09};
  localparam logic [7:0]  bad_a [3]   = '{8'h0a, 8'h0b, 8'h04};
  localparam logic [7:0]  bad_d [3]   = '{8'h00, 8'h00, 8'h5a};
  localparam logic [15:0] sut_tab [4] = '{16'h03e8, 16'h07d0, 16'h03e8, 16'h0fa0};

  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        por  = 1'b0;
  logic        send = 1'b0;
  logic        psel, pen, pwr, pready, pslverr, pin_rst, brownout_detector, dbg, in_system_programming, usig, tris, busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] sut_us;
  logic [1:0]  lock;
  lfc_clk_t    clk_src;
  int          err_count = 0;
  int          checks = 0;
  int          cycles = 0;

  lfc_top u_lfc_top (.mclk_i(mclk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .por_i(por), .session_end_i(send),
    .clock_source_o(clk_src), .startup_us_o(sut_us), .reset_pin_is_reset_o(pin_rst),
    .bod_fuse_o(brownout_detector), .on_chip_debug_en_o(dbg), .isp_entry_allowed_o(in_system_programming),
    .usig_prog_en_o(usig), .ports_tristate_o(tris), .lock_mode_o(lock), .busy_o(busy));
  lfc_prog u_lfc_prog (.mclk_i(mclk), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));

  always #2.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    u_lfc_prog.xfer(1'b0, a, 32'h0);
    q = u_lfc_prog.q;
  endtask

  // refusal flag compared, then cleared
  task automatic stat(input logic x);
    rd(OFF_STATUS);
    chk("refused", 32'(q[ST_REFUSED]), 32'(x));
    u_lfc_prog.xfer(1'b1, OFF_STATUS, 32'h2);
  endtask

  task automatic mem(input lfc_space_t sp, input logic [7:0] a, input logic [31:0] x);
    u_lfc_prog.nv(OP_READ, sp, 1'b0, a, 8'h00);
    rd(OFF_RDATA);
    chk("mem", q, x);
  endtask

  task automatic idle();
    do
      rd(OFF_STATUS);
    while (q[ST_BUSY] !== 1'b0);
  endtask

  task automatic pulse(input logic p);
    @(posedge mclk);
    if (p)
      por <= 1'b1;
    else
      send <= 1'b1;
    @(posedge mclk);
    por  <= 1'b0;
    send <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk("outs", 32'({clk_src, sut_us, pin_rst, brownout_detector, dbg, in_system_programming, usig, tris, lock, busy}),
        32'({2'h3, 16'h0fa0, 9'h1aa}));
    rd(OFF_FUSES);
    chk("fuses", q, 32'h7ff);
    rd(8'h40);
    chk("unmapped", {31'h0, u_lfc_prog.e}, 32'h1);
    foreach (fz[i])
      u_lfc_prog.fuse(fz[i], 1'b0);
    u_lfc_prog.fuse(8'h04, 1'b1);
    rd(OFF_FUSES);
    chk("fuse_clr", q, 32'h42f);
    chk("pin_early", 32'(pin_rst), 32'h1);
    pulse(1'b0);
    chk("session", 32'({pin_rst, dbg, in_system_programming, usig, tris, clk_src}), 32'h2b);
    rd(OFF_CFG);
    chk("cfg", q, 32'h42f);
    for (int i = 0; i < 4; i++)
    begin
      u_lfc_prog.nv(OP_WRFUSE_AE, SP_FUSE, 1'b0, 8'h00, 8'hff);
      for (int b = 0; b < 4; b++)
        if (!i[b % 2])
          u_lfc_prog.fuse(8'(b), 1'b0);
      pulse(1'b0);
      chk("clk_hold", 32'(clk_src), 32'(i == 0 ? 3 : i - 1));
      pulse(1'b1);
      chk("clk_src", 32'(clk_src), 32'(i));
      chk("startup", 32'(sut_us), 32'(sut_tab[i]));
    end
    rd(OFF_FUSES);
    chk("row_erase", q, 32'h7ff);
    foreach (bad_a[i])
    begin
      u_lfc_prog.nv(OP_WRFUSE, SP_FUSE, 1'b0, bad_a[i], bad_d[i]);
      stat(1'b1);
    end
    rd(OFF_FUSES);
    chk("no_change", q, 32'h7ff);
    u_lfc_prog.nv(OP_LOAD, SP_CODE, 1'b0, 8'h03, 8'h3c);
    u_lfc_prog.nv(OP_LOAD, SP_CODE, 1'b0, 8'h02, 8'h5a);
    u_lfc_prog.nv(OP_WRPAGE, SP_CODE, 1'b0, 8'h00, 8'h00);
    mem(SP_CODE, 8'h02, 32'hda);
    idle();
    mem(SP_CODE, 8'h02, 32'h5a);
    mem(SP_CODE, 8'h03, 32'h3c);
    u_lfc_prog.nv(OP_ERASE, SP_CODE, 1'b0, 8'h00, 8'h00);
    mem(SP_CODE, 8'h03, 32'h7f);
    idle();
    mem(SP_CODE, 8'h03, 32'hff);
    u_lfc_prog.fuse(8'h06, 1'b0);
    pulse(1'b0);
    u_lfc_prog.nv(OP_WRLOCK, SP_LOCK, 1'b0, 8'h00, 8'h00);
    u_lfc_prog.fuse(8'h04, 1'b0);
    stat(1'b1);
    chk("mode2", 32'({lock, dbg}), 32'h5);
    rd(OFF_FUSES);
    chk("fuse_locked", q, 32'h7bf);
    u_lfc_prog.nv(OP_LOAD, SP_CODE, 1'b1, 8'h01, 8'ha5);
    u_lfc_prog.nv(OP_WRPAGE, SP_CODE, 1'b1, 8'h00, 8'h00);
    stat(1'b0);
    idle();
    mem(SP_CODE, 8'h01, 32'ha5);
    u_lfc_prog.nv(OP_WRLOCK, SP_LOCK, 1'b0, 8'h01, 8'h00);
    u_lfc_prog.nv(OP_WRLOCK, SP_LOCK, 1'b0, 8'h00, 8'hff);
    chk("mode3", 32'({lock, dbg}), 32'h6);
    u_lfc_prog.nv(OP_READ, SP_CODE, 1'b0, 8'h01, 8'h00);
    stat(1'b1);
    rd(OFF_FUSES);
    chk("fuse_read", q, 32'h7bf);
    u_lfc_prog.nv(OP_ERASE, SP_CODE, 1'b0, 8'h00, 8'h00);
    idle();
    chk("mode1", 32'({lock, dbg}), 32'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
